// file: hdl/wkt_pkg.sv
// package: constants, register map and carriers of the wake-up timer
package wkt_pkg;
   // -----------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------
   localparam logic [7:0] OFF_CFG = 8'h00;
   localparam logic [7:0] OFF_EXP = 8'h01;
   localparam logic [7:0] OFF_MANT_HI = 8'h02;
   localparam logic [7:0] OFF_MANT_LO = 8'h03;
   localparam logic [7:0] OFF_DUTY = 8'h04;
   localparam logic [7:0] OFF_TOP_IE = 8'h05;
   localparam logic [7:0] OFF_CHIP_IE = 8'h06;
   localparam logic [7:0] OFF_CLK_CFG = 8'h07;
   localparam logic [7:0] OFF_GPIO_MODE = 8'h08;
   localparam logic [7:0] OFF_IRQ_MODE = 8'h09;
   localparam logic [7:0] OFF_TX_CTL = 8'h0A;
   localparam logic [7:0] OFF_BATT_TH = 8'h0B;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_STATE = 8'h0D;
   // -----------------------------------------------------------
   // field positions and codes
   // -----------------------------------------------------------
   localparam int STS_TIMER = 0;
   localparam int STS_PKT = 1;
   localparam int STS_BATT = 2;
   localparam int STS_CAL = 3;
   localparam int TOP_CHIP = 0;
   localparam int TOP_PKT = 1;
   localparam int CHIP_TIMER = 0;
   localparam int CHIP_BATT = 1;
   localparam logic [1:0] DUTY_OFF = 2'h0;
   localparam logic [1:0] DUTY_TX = 2'h2;
   localparam logic [2:0] SRC_RC = 3'h0;
   localparam logic [2:0] SRC_XTAL = 3'h1;
   localparam logic [5:0] GPIO_MODE_TIMER = 6'h0E;
   localparam logic [5:0] IRQ_MODE_TIMER = 6'h27;
   // -----------------------------------------------------------
   // reset values and timing
   // -----------------------------------------------------------
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [6:0] RST_TRIM = 7'h40;
   localparam logic [33:0] UNIT_BASE = 34'h4;
   localparam logic [22:0] CAL_BASE_TICKS = 23'h8000;
   localparam logic [5:0] CAL_RC_TICKS = 6'h20;
   localparam int XO_HZ = 30000000;
   localparam int SLOW_HZ = 32768;
   localparam logic [15:0] CAL_XO_EXPECT =
      16'((64'(XO_HZ) * 64'(CAL_RC_TICKS)) / 64'(SLOW_HZ));
   // -----------------------------------------------------------
   // carriers
   // -----------------------------------------------------------
   typedef struct packed {
      logic [2:0] recalibration_interval;
      logic cal_enable;
      logic [1:0] duty_cycle_mode_select;
      logic battery_check_per_interval_enable;
      logic wake_timer_enable;
   } wkt_cfg_type;
   typedef struct packed {
      logic [1:0] spare;
      logic post_expiry_state_select;
      logic [4:0] period_exponent;
   } wkt_exp_type;
   typedef enum {PS_READY, PS_SLEEP, PS_TX} wkt_pstate_type;
   typedef enum {CAL_IDLE, CAL_XO_WAIT, CAL_MEASURE} wkt_cal_type;
endpackage

// file: hdl/wkt_timer.sv
// wake-up timer with low duty cycle transmit and RC recalibration
`timescale 1ns/1ps
// Operation
// - wake counter clocked by RC or crystal 32 kHz tick, per source select
// - timer counts programmed period in sleep when enabled before sleep entry
// - expiry asserts interrupt pin only if timer interrupt enabled
// - wake period is mantissa times 4 times 2^exponent slow ticks
// - RC calibrated on power-up command and on leaving shutdown
// - periodic recalibration at selected interval when calibration enabled
// - calibration starts 30 MHz crystal, compares RC, adjusts RC trim
// - duty mode field 0 disables, 2 selects transmit low duty cycle
// - mantissa from high and low bytes, five-bit exponent property
// - after expiry go ready when state select 0, sleep when 1
// - chip status interrupts reach pin only with chip status enable set
// - expiry shown on gpio at mode 14 and irq pin at mode 39
// - transmit start field 1 begins transmission on timer expiry
// - duty period is multiplier times 4 times 2^exponent slow ticks
// - duty mode wakes transmitter each period to send buffered packet
// - packet sent in duty mode drives interrupt pin low when enabled, except at irq mode 39
// - after duty mode transmit return at once to timer state
// - battery compared to threshold each expiry, 1.5 V plus 50 mV steps
module wkt_timer (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   input wire logic rc_tick,
   input wire logic xtal32_tick,
   input wire logic xo_tick,
   input wire logic xo_ready,
   input wire logic sleep_req,
   input wire logic power_up_cmd,
   input wire logic shutdown_exit,
   input wire logic packet_sent,
   input wire logic battery_done,
   input wire logic battery_low,
   output logic xo_start,
   output logic [6:0] rc_trim,
   output logic battery_measure,
   output logic [7:0] battery_threshold,
   output logic tx_start,
   output logic [1:0] power_state,
   output logic interrupt_request_pin_n,
   output logic general_pin
);
   // -----------------------------------------------------------
   // registers
   // -----------------------------------------------------------
   wkt_pkg::wkt_cfg_type cfg_r;
   wkt_pkg::wkt_exp_type exp_r;
   logic [7:0] mant_hi_r, mant_lo_r, duty_r, top_ie_r, chip_ie_r;
   logic [2:0] clk_sel_r;
   logic [5:0] gpio_mode_r, irq_mode_r;
   logic tx_on_expiry_r;
   logic [7:0] batt_th_r;
   logic [3:0] status_r;
   logic [7:0] rdata_r;
   logic [15:0] period_mantissa;
   logic [33:0] unit_len;
   logic [33:0] pre_r;
   logic [15:0] wake_cnt_r, duty_cnt_r;
   logic armed_r;
   logic slow_tick, unit_end, wake_exp, duty_exp, duty_mode;
   wkt_pkg::wkt_pstate_type ps_r;
   wkt_pkg::wkt_cal_type cal_r;
   logic [22:0] cal_tmr_r;
   logic [5:0] cal_rc_r;
   logic [15:0] cal_xo_r;
   logic cal_req, cal_done;
   logic [6:0] trim_r;
   logic tx_start_r, batt_meas_r;
   logic status_rd;

   assign period_mantissa = {mant_hi_r, mant_lo_r};
   assign duty_mode = (cfg_r.duty_cycle_mode_select == wkt_pkg::DUTY_TX);

   // -----------------------------------------------------------
   // register port
   // -----------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cfg_r <= wkt_pkg::wkt_cfg_type'(wkt_pkg::RST_REG);
         exp_r <= wkt_pkg::wkt_exp_type'(wkt_pkg::RST_REG);
         mant_hi_r <= wkt_pkg::RST_REG;
         mant_lo_r <= wkt_pkg::RST_REG;
         duty_r <= wkt_pkg::RST_REG;
         top_ie_r <= wkt_pkg::RST_REG;
         chip_ie_r <= wkt_pkg::RST_REG;
         clk_sel_r <= wkt_pkg::SRC_RC;
         gpio_mode_r <= 6'h00;
         irq_mode_r <= 6'h00;
         tx_on_expiry_r <= 1'b0;
         batt_th_r <= wkt_pkg::RST_REG;
      end else if (wr_stb) begin
         case (addr)
            wkt_pkg::OFF_CFG: cfg_r <= wkt_pkg::wkt_cfg_type'(wdata);
            wkt_pkg::OFF_EXP: exp_r <= wkt_pkg::wkt_exp_type'({2'h0, wdata[5:0]});
            wkt_pkg::OFF_MANT_HI: mant_hi_r <= wdata;
            wkt_pkg::OFF_MANT_LO: mant_lo_r <= wdata;
            wkt_pkg::OFF_DUTY: duty_r <= wdata;
            wkt_pkg::OFF_TOP_IE: top_ie_r <= {6'h00, wdata[1:0]};
            wkt_pkg::OFF_CHIP_IE: chip_ie_r <= {6'h00, wdata[1:0]};
            wkt_pkg::OFF_CLK_CFG: clk_sel_r <= wdata[2:0];
            wkt_pkg::OFF_GPIO_MODE: gpio_mode_r <= wdata[5:0];
            wkt_pkg::OFF_IRQ_MODE: irq_mode_r <= wdata[5:0];
            wkt_pkg::OFF_TX_CTL: tx_on_expiry_r <= wdata[0];
            wkt_pkg::OFF_BATT_TH: batt_th_r <= wdata;
            default: ;
         endcase
      end
   end

   assign status_rd = rd_stb && (addr == wkt_pkg::OFF_STATUS);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
      end else if (rd_stb) begin
         case (addr)
            wkt_pkg::OFF_CFG: rdata_r <= cfg_r;
            wkt_pkg::OFF_EXP: rdata_r <= exp_r;
            wkt_pkg::OFF_MANT_HI: rdata_r <= mant_hi_r;
            wkt_pkg::OFF_MANT_LO: rdata_r <= mant_lo_r;
            wkt_pkg::OFF_DUTY: rdata_r <= duty_r;
            wkt_pkg::OFF_TOP_IE: rdata_r <= top_ie_r;
            wkt_pkg::OFF_CHIP_IE: rdata_r <= chip_ie_r;
            wkt_pkg::OFF_CLK_CFG: rdata_r <= {5'h00, clk_sel_r};
            wkt_pkg::OFF_GPIO_MODE: rdata_r <= {2'h0, gpio_mode_r};
            wkt_pkg::OFF_IRQ_MODE: rdata_r <= {2'h0, irq_mode_r};
            wkt_pkg::OFF_TX_CTL: rdata_r <= {7'h00, tx_on_expiry_r};
            wkt_pkg::OFF_BATT_TH: rdata_r <= batt_th_r;
            wkt_pkg::OFF_STATUS: rdata_r <= {4'h0, status_r};
            wkt_pkg::OFF_STATE: rdata_r <= {armed_r, trim_r};
            default: rdata_r <= 8'h00;
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end

   // -----------------------------------------------------------
   // slow clock and period counters
   // -----------------------------------------------------------
   assign slow_tick = (clk_sel_r == wkt_pkg::SRC_XTAL) ? xtal32_tick : rc_tick;
   assign unit_len = wkt_pkg::UNIT_BASE << exp_r.period_exponent;
   assign unit_end = armed_r && slow_tick && (pre_r == unit_len - 34'h1);
   assign wake_exp = unit_end && (period_mantissa != 16'h0000) &&
                     (wake_cnt_r == period_mantissa - 16'h1);
   assign duty_exp = unit_end && duty_mode && (duty_r != 8'h00) &&
                     (duty_cnt_r == {8'h00, duty_r} - 16'h1);

   // armed at sleep entry, held while enabled
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         armed_r <= 1'b0;
      end else if (!cfg_r.wake_timer_enable) begin
         armed_r <= 1'b0;
      end else if (sleep_req) begin
         armed_r <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || !armed_r) begin
         pre_r <= 34'h0;
         wake_cnt_r <= 16'h0000;
         duty_cnt_r <= 16'h0000;
      end else if (slow_tick) begin
         pre_r <= unit_end ? 34'h0 : pre_r + 34'h1;
         if (unit_end) begin
            wake_cnt_r <= wake_exp ? 16'h0000 : wake_cnt_r + 16'h1;
            duty_cnt_r <= duty_exp ? 16'h0000 : duty_cnt_r + 16'h1;
         end
      end
   end

   // -----------------------------------------------------------
   // power state sequencing
   // -----------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ps_r <= wkt_pkg::PS_READY;
         tx_start_r <= 1'b0;
      end else begin
         tx_start_r <= 1'b0;
         case (ps_r)
            wkt_pkg::PS_READY: begin
               if (sleep_req) begin
                  ps_r <= wkt_pkg::PS_SLEEP;
               end
            end
            wkt_pkg::PS_SLEEP: begin
               if (duty_exp || (wake_exp && tx_on_expiry_r)) begin
                  ps_r <= wkt_pkg::PS_TX;
                  tx_start_r <= 1'b1;
               end else if (wake_exp && !exp_r.post_expiry_state_select) begin
                  ps_r <= wkt_pkg::PS_READY;
               end
            end
            wkt_pkg::PS_TX: begin
               if (packet_sent) begin
                  ps_r <= duty_mode ? wkt_pkg::PS_SLEEP : wkt_pkg::PS_READY;
               end
            end
            default: ps_r <= wkt_pkg::PS_READY;
         endcase
      end
   end

   // -----------------------------------------------------------
   // battery check per interval
   // -----------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         batt_meas_r <= 1'b0;
      end else begin
         batt_meas_r <= wake_exp && cfg_r.battery_check_per_interval_enable;
      end
   end

   // -----------------------------------------------------------
   // RC calibration against the 30 MHz crystal
   // -----------------------------------------------------------
   assign cal_req = power_up_cmd || shutdown_exit ||
                    (cfg_r.cal_enable && slow_tick &&
                     (cal_tmr_r == (wkt_pkg::CAL_BASE_TICKS << cfg_r.recalibration_interval)
                      - 23'h1));
   assign cal_done = (cal_r == wkt_pkg::CAL_MEASURE) && rc_tick &&
                     (cal_rc_r == wkt_pkg::CAL_RC_TICKS - 6'h1);

   always_ff @(posedge core_clk) begin
      if (!rst_n || !cfg_r.cal_enable || cal_req) begin
         cal_tmr_r <= 23'h0;
      end else if (slow_tick) begin
         cal_tmr_r <= cal_tmr_r + 23'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cal_r <= wkt_pkg::CAL_IDLE;
         cal_rc_r <= 6'h00;
         cal_xo_r <= 16'h0000;
      end else begin
         case (cal_r)
            wkt_pkg::CAL_IDLE: begin
               if (cal_req) begin
                  cal_r <= wkt_pkg::CAL_XO_WAIT;
               end
            end
            wkt_pkg::CAL_XO_WAIT: begin
               cal_rc_r <= 6'h00;
               cal_xo_r <= 16'h0000;
               if (xo_ready && rc_tick) begin
                  cal_r <= wkt_pkg::CAL_MEASURE;
               end
            end
            wkt_pkg::CAL_MEASURE: begin
               if (rc_tick) begin
                  cal_rc_r <= cal_rc_r + 6'h01;
               end
               if (xo_tick && cal_xo_r != 16'hFFFF) begin
                  cal_xo_r <= cal_xo_r + 16'h0001;
               end
               if (cal_done) begin
                  cal_r <= wkt_pkg::CAL_IDLE;
               end
            end
            default: cal_r <= wkt_pkg::CAL_IDLE;
         endcase
      end
   end

   // more crystal edges per window means the RC runs slow
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         trim_r <= wkt_pkg::RST_TRIM;
      end else if (cal_done) begin
         if (cal_xo_r > wkt_pkg::CAL_XO_EXPECT && trim_r != 7'h7F) begin
            trim_r <= trim_r + 7'h01;
         end else if (cal_xo_r < wkt_pkg::CAL_XO_EXPECT && trim_r != 7'h00) begin
            trim_r <= trim_r - 7'h01;
         end
      end
   end

   // -----------------------------------------------------------
   // interrupt status and pins
   // -----------------------------------------------------------
   // set wins over the clear-on-read
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         status_r <= 4'h0;
      end else begin
         status_r[wkt_pkg::STS_TIMER] <= wake_exp ||
            (status_r[wkt_pkg::STS_TIMER] && !status_rd);
         status_r[wkt_pkg::STS_PKT] <= (packet_sent && duty_mode && ps_r == wkt_pkg::PS_TX) ||
            (status_r[wkt_pkg::STS_PKT] && !status_rd);
         status_r[wkt_pkg::STS_BATT] <= (battery_done && battery_low) ||
            (status_r[wkt_pkg::STS_BATT] && !status_rd);
         status_r[wkt_pkg::STS_CAL] <= cal_done ||
            (status_r[wkt_pkg::STS_CAL] && !status_rd);
      end
   end

   logic chip_irq, pkt_irq, irq_level, gpio_level;
   assign chip_irq = top_ie_r[wkt_pkg::TOP_CHIP] &&
      ((status_r[wkt_pkg::STS_TIMER] && chip_ie_r[wkt_pkg::CHIP_TIMER]) ||
       (status_r[wkt_pkg::STS_BATT] && chip_ie_r[wkt_pkg::CHIP_BATT]));
   assign pkt_irq = top_ie_r[wkt_pkg::TOP_PKT] && status_r[wkt_pkg::STS_PKT];
   assign irq_level = (irq_mode_r == wkt_pkg::IRQ_MODE_TIMER) ?
      (top_ie_r[wkt_pkg::TOP_CHIP] && chip_ie_r[wkt_pkg::CHIP_TIMER] &&
       status_r[wkt_pkg::STS_TIMER]) : (chip_irq || pkt_irq);
   assign gpio_level = (gpio_mode_r == wkt_pkg::GPIO_MODE_TIMER) &&
                       status_r[wkt_pkg::STS_TIMER];

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         interrupt_request_pin_n <= 1'b1;
         general_pin <= 1'b0;
      end else begin
         interrupt_request_pin_n <= !irq_level;
         general_pin <= gpio_level;
      end
   end
   assign rdata = rdata_r;
   assign xo_start = (cal_r != wkt_pkg::CAL_IDLE);
   assign rc_trim = trim_r;
   assign battery_measure = batt_meas_r;
   assign battery_threshold = batt_th_r;
   assign tx_start = tx_start_r;
   assign power_state = (ps_r == wkt_pkg::PS_TX) ? 2'h2 :
                        (ps_r == wkt_pkg::PS_SLEEP) ? 2'h1 : 2'h0;
endmodule

// file: tb/wkt_timer_checker.sv
// port-level assertions for the wake-up timer
`timescale 1ns/1ps
module wkt_timer_checker (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic rd_stb,
   input wire logic [7:0] rdata,
   input wire logic [6:0] rc_trim,
   input wire logic xo_start,
   input wire logic tx_start,
   input wire logic [1:0] power_state,
   input wire logic battery_measure,
   input wire logic packet_sent,
   input wire logic interrupt_request_pin_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // multi-step behaviours
   // ----------------------------------------
   sequence s_xo_run;
      xo_start [*8];
   endsequence
   sequence s_quiet_meas;
      !battery_measure [*3];
   endsequence
   // ----------------------------------------
   // properties
   // ----------------------------------------
   a_reset_values: assert property (disable iff (1'b0) !rst_n |=> rdata == 8'h00 &&
      interrupt_request_pin_n && rc_trim == 7'h40 && power_state == 2'h0 && !tx_start)
      else $error("outputs not at reset values");
   a_rdata_idle: assert property (!rd_stb |=> rdata == 8'h00)
      else $error("read data outside read cycle");
   a_tx_pulse: assert property (tx_start |=> !tx_start)
      else $error("transmit start longer than one cycle");
   a_tx_state: assert property (tx_start |-> power_state == 2'h2)
      else $error("transmit start without transmit state");
   a_trim_step: assert property ($past(rst_n) && rc_trim != $past(rc_trim) |->
      rc_trim == $past(rc_trim) + 7'h01 || rc_trim == $past(rc_trim) - 7'h01)
      else $error("trim moved by more than one step");
   a_trim_in_cal: assert property ($past(rst_n) && rc_trim != $past(rc_trim) |->
      $past(xo_start))
      else $error("trim changed outside calibration");
   a_xo_hold: assert property ($rose(xo_start) |-> s_xo_run)
      else $error("crystal request dropped too early");
   a_meas_gap: assert property (battery_measure |=> s_quiet_meas)
      else $error("battery measure repeated too soon");
   a_pkt_leave: assert property (power_state == 2'h2 && packet_sent |=>
      power_state != 2'h2)
      else $error("transmit state kept after packet sent");
   a_state_legal: assert property (power_state != 2'h3)
      else $error("illegal power state");
   a_tx_entry: assert property ($rose(power_state == 2'h2) |-> tx_start)
      else $error("transmit state entered without start pulse");
endmodule
bind wkt_timer wkt_timer_checker u_chk (.core_clk(core_clk), .rst_n(rst_n),
   .rd_stb(rd_stb), .rdata(rdata), .rc_trim(rc_trim), .xo_start(xo_start),
   .tx_start(tx_start), .power_state(power_state), .battery_measure(battery_measure),
   .packet_sent(packet_sent), .interrupt_request_pin_n(interrupt_request_pin_n));

// file: tb/wkt_env_model.sv
// model of slow clocks, crystal, packet handler and battery comparator
`timescale 1ns/1ps
module wkt_env_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [15:0] rc_div,
   input wire logic [15:0] xt_div,
   input wire logic xo_start,
   input wire logic tx_start,
   input wire logic battery_measure,
   output logic rc_tick,
   output logic xtal32_tick,
   output logic xo_tick,
   output logic xo_ready,
   output logic packet_sent,
   output logic battery_done,
   output logic battery_low
);
   logic [15:0] rc_cnt_r;
   logic [15:0] xt_cnt_r;
   logic [3:0] xo_up_r;
   logic [3:0] tx_dly_r;
   logic [1:0] bat_dly_r;
   // ----------------------------------------
   // slow tick sources, free running
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      rc_cnt_r <= (!rst_n || rc_cnt_r >= rc_div - 16'h0001) ? 16'h0000 : rc_cnt_r + 16'h0001;
      xt_cnt_r <= (!rst_n || xt_cnt_r >= xt_div - 16'h0001) ? 16'h0000 : xt_cnt_r + 16'h0001;
      rc_tick <= rst_n && rc_cnt_r == 16'h0000;
      xtal32_tick <= rst_n && xt_cnt_r == 16'h0000;
   end
   // ----------------------------------------
   // crystal runs only while requested
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      xo_up_r <= (rst_n && xo_start) ? {xo_up_r[2:0], 1'b1} : 4'h0;
   end
   assign xo_ready = xo_up_r[3];
   assign xo_tick = xo_up_r[3];
   // packet finishes a few cycles after transmit start
   always_ff @(posedge core_clk) begin
      tx_dly_r <= !rst_n ? 4'h0 : tx_start ? 4'h6 : tx_dly_r - 4'(tx_dly_r != 4'h0);
      packet_sent <= rst_n && tx_dly_r == 4'h1;
   end
   // low battery answer; level toggles outside its valid cycle
   always_ff @(posedge core_clk) begin
      bat_dly_r <= !rst_n ? 2'h0 : battery_measure ? 2'h2 : bat_dly_r - 2'(bat_dly_r != 2'h0);
      battery_done <= rst_n && bat_dly_r == 2'h1;
      battery_low <= rst_n && (bat_dly_r == 2'h1 || !battery_low);
   end
endmodule

// file: tb/wkt_timer_tb.sv
// self-checking testbench of the wake-up timer
`timescale 1ns/1ps
module wkt_timer_tb;
   logic core_clk, rst_n, wr_stb, rd_stb, sleep_req, power_up_cmd, shutdown_exit, src;
   logic [7:0] addr, wdata, rdata, battery_threshold;
   logic rc_tick, xtal32_tick, xo_tick, xo_ready, packet_sent, battery_done, battery_low;
   logic xo_start, battery_measure, tx_start, pin_n, general_pin;
   logic [6:0] rc_trim;
   logic [1:0] power_state;
   logic [15:0] rc_div, xt_div;
   int error_cnt, cmp_count, tick_n, meas_n, tx_n, t0, m0, n;
   wkt_timer dut (.core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .rc_tick(rc_tick),
      .xtal32_tick(xtal32_tick), .xo_tick(xo_tick), .xo_ready(xo_ready),
      .sleep_req(sleep_req), .power_up_cmd(power_up_cmd), .shutdown_exit(shutdown_exit),
      .packet_sent(packet_sent), .battery_done(battery_done), .battery_low(battery_low),
      .xo_start(xo_start), .rc_trim(rc_trim), .battery_measure(battery_measure),
      .battery_threshold(battery_threshold), .tx_start(tx_start),
      .power_state(power_state), .interrupt_request_pin_n(pin_n),
      .general_pin(general_pin));
   wkt_env_model env (.core_clk(core_clk), .rst_n(rst_n), .rc_div(rc_div), .xt_div(xt_div),
      .xo_start(xo_start), .tx_start(tx_start), .battery_measure(battery_measure),
      .rc_tick(rc_tick), .xtal32_tick(xtal32_tick), .xo_tick(xo_tick), .xo_ready(xo_ready),
      .packet_sent(packet_sent), .battery_done(battery_done), .battery_low(battery_low));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      tick_n <= tick_n + int'(src ? xtal32_tick : rc_tick);
      meas_n <= meas_n + int'(battery_measure);
      tx_n <= tx_n + int'(tx_start);
   end
   // ----------------------------------------
   // access and check tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         error_cnt++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   task automatic pulse(input logic [2:0] w);
      @(posedge core_clk);
      {shutdown_exit, power_up_cmd, sleep_req} <= w;
      @(posedge core_clk);
      {shutdown_exit, power_up_cmd, sleep_req} <= 3'h0;
      #1;
      t0 = tick_n;
      m0 = meas_n;
   endtask
   // 0: gpio up, 1: transmit start, 2: calibration over, 3: calibration begun
   task automatic wait_sig(input int w);
      for (n = 0; n < 50000; n++) begin
         @(posedge core_clk);
         #1;
         if (w == 0 ? general_pin === 1'b1 : w == 1 ? tx_start === 1'b1 : xo_start === (w == 3))
            break;
      end
      if (n == 50000)
         chk(8'h00, 8'hFF);
   endtask
   task automatic summarize;
      if (error_cnt == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #1000000;
      error_cnt++;
      summarize();
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      {addr, wdata, wr_stb, rd_stb, sleep_req, power_up_cmd, shutdown_exit, src} = '0;
      {error_cnt, cmp_count, tick_n, meas_n, tx_n} = '0;
      rc_div = 16'h0005;
      xt_div = 16'h0007;
      rst_n = 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      chk({general_pin, rc_trim}, 8'h40);
      chk({7'h0, pin_n}, 8'h01);
      chk({6'h0, power_state}, 8'h00);
      chk(battery_threshold, 8'h00);
      rd(wkt_pkg::OFF_CFG, 8'h00);
      rd(8'h20, 8'h00);
      rd(wkt_pkg::OFF_STATE, 8'h40);
      wr(wkt_pkg::OFF_BATT_TH, 8'h1F);
      #1 chk(battery_threshold, 8'h1F);
      wr(wkt_pkg::OFF_MANT_HI, 8'hA5);
      rd(wkt_pkg::OFF_MANT_HI, 8'hA5);
      wr(wkt_pkg::OFF_EXP, 8'h3F);
      rd(wkt_pkg::OFF_EXP, 8'h3F);
      // periodic expiry on each slow source
      for (int i = 0; i < 2; i++) begin
         src = i[0];
         wr(wkt_pkg::OFF_CLK_CFG, {7'h0, src});
         wr(wkt_pkg::OFF_GPIO_MODE, 8'h0E);
         wr(wkt_pkg::OFF_IRQ_MODE, src ? 8'h27 : 8'h00);
         wr(wkt_pkg::OFF_TOP_IE, 8'h01);
         wr(wkt_pkg::OFF_CHIP_IE, 8'h01);
         wr(wkt_pkg::OFF_EXP, {2'h0, src, 5'h01});
         wr(wkt_pkg::OFF_MANT_HI, 8'h00);
         wr(wkt_pkg::OFF_MANT_LO, 8'h02);
         wr(wkt_pkg::OFF_CFG, 8'h03);
         pulse(3'h1);
         for (int k = 1; k < 3; k++) begin
            wait_sig(0);
            chk(8'(tick_n - t0), 8'(16 * k));
            chk({7'h0, pin_n}, 8'h00);
            chk({6'h0, power_state}, {7'h0, src});
            chk(8'(meas_n - m0), 8'(k));
            repeat (6) @(posedge core_clk);
            rd(wkt_pkg::OFF_STATUS, 8'h05);
            rd(wkt_pkg::OFF_STATUS, 8'h00);
            repeat (2) @(posedge core_clk);
            #1 chk({6'h0, pin_n, general_pin}, 8'h02);
         end
         wr(wkt_pkg::OFF_CFG, 8'h00);
      end
      // transmit on expiry with top-level enable off
      wr(wkt_pkg::OFF_IRQ_MODE, 8'h00);
      wr(wkt_pkg::OFF_CHIP_IE, 8'h01);
      wr(wkt_pkg::OFF_TOP_IE, 8'h00);
      wr(wkt_pkg::OFF_TX_CTL, 8'h01);
      wr(wkt_pkg::OFF_EXP, 8'h00);
      wr(wkt_pkg::OFF_MANT_LO, 8'h01);
      wr(wkt_pkg::OFF_CFG, 8'h01);
      pulse(3'h1);
      wait_sig(1);
      chk(8'(tick_n - t0), 8'h04);
      chk({6'h0, power_state}, 8'h02);
      wr(wkt_pkg::OFF_CFG, 8'h00);
      repeat (10) @(posedge core_clk);
      #1 chk({5'h0, power_state, pin_n}, 8'h01);
      rd(wkt_pkg::OFF_STATUS, 8'h01);
      wr(wkt_pkg::OFF_TX_CTL, 8'h00);
      // transmit low duty cycle
      wr(wkt_pkg::OFF_MANT_LO, 8'h00);
      wr(wkt_pkg::OFF_DUTY, 8'h03);
      wr(wkt_pkg::OFF_TOP_IE, 8'h02);
      wr(wkt_pkg::OFF_CFG, 8'h09);
      pulse(3'h1);
      wait_sig(1);
      chk(8'(tick_n - t0), 8'h0C);
      chk({6'h0, power_state}, 8'h02);
      repeat (12) @(posedge core_clk);
      #1 chk({5'h0, power_state, pin_n}, 8'h02);
      rd(wkt_pkg::OFF_STATUS, 8'h02);
      wr(wkt_pkg::OFF_CFG, 8'h01);
      pulse(3'h1);
      m0 = tx_n;
      repeat (200) @(posedge core_clk);
      chk(8'(tx_n - m0), 8'h00);
      wr(wkt_pkg::OFF_CFG, 8'h00);
      // calibration on boot and on leaving shutdown
      rc_div <= 16'h03B6;
      pulse(3'h2);
      chk({7'h0, xo_start}, 8'h01);
      wait_sig(2);
      chk({1'b0, rc_trim}, 8'h41);
      rd(wkt_pkg::OFF_STATUS, 8'h08);
      rc_div <= 16'h0064;
      pulse(3'h4);
      wait_sig(2);
      chk({1'b0, rc_trim}, 8'h40);
      rd(wkt_pkg::OFF_STATE, 8'h40);
      // periodic recalibration on a fast slow clock
      xt_div <= 16'h0001;
      wr(wkt_pkg::OFF_CFG, 8'h10);
      t0 = tick_n;
      wait_sig(3);
      chk(8'((tick_n - t0) >> 8), 8'h80);
      wait_sig(2);
      chk({1'b0, rc_trim}, 8'h3F);
      summarize();
   end
endmodule
